// File: verilog/twm_map.vh
/*
  Constants for the 16-bit timer waveform mode control slice: register
  offsets, field positions, reset values, mode codes and fixed tops.
  Assumes it is included by bare name from the design files.
*/
`ifndef TWM_MAP_VH
`define TWM_MAP_VH

// Register offsets on the 4-bit register port
`define TWM_OFS_CTRL_A      4'h0
`define TWM_OFS_CTRL_B      4'h1
`define TWM_OFS_MATCH_A_LO  4'h2
`define TWM_OFS_MATCH_A_HI  4'h3
`define TWM_OFS_MATCH_B_LO  4'h4
`define TWM_OFS_MATCH_B_HI  4'h5
`define TWM_OFS_MATCH_C_LO  4'h6
`define TWM_OFS_MATCH_C_HI  4'h7
`define TWM_OFS_CAPT_LO     4'h8
`define TWM_OFS_CAPT_HI     4'h9
`define TWM_OFS_STATUS      4'hA

// Reset values
`define TWM_RST_CTRL_A      8'h00
`define TWM_RST_CTRL_B      8'h00
`define TWM_RST_WORD        16'h0000

// Control A fields
`define TWM_CA_MODE_A_HI    7
`define TWM_CA_MODE_A_LO    6
`define TWM_CA_MODE_B_HI    5
`define TWM_CA_MODE_B_LO    4
`define TWM_CA_MODE_C_HI    3
`define TWM_CA_MODE_C_LO    2
`define TWM_CA_WSEL_HI      1
`define TWM_CA_WSEL_LO      0

// Control B fields
`define TWM_CB_RSVD         5
`define TWM_CB_WSEL_HI      4
`define TWM_CB_WSEL_LO      3
`define TWM_CB_CSEL_HI      2
`define TWM_CB_CSEL_LO      0
`define TWM_CB_READ_MASK    8'hDF

// Status fields
`define TWM_ST_OVF          0
`define TWM_ST_DUAL         1
`define TWM_ST_FAST         2
`define TWM_ST_CAPT_OFF     3
`define TWM_ST_LEVEL_LO     4
`define TWM_ST_LEVEL_HI     6

// Compare output mode codes
`define TWM_OM_OFF          2'h0
`define TWM_OM_TOGGLE       2'h1
`define TWM_OM_CLEAR        2'h2
`define TWM_OM_SET          2'h3

// Waveform select codes
`define TWM_WM_NORMAL       4'h0
`define TWM_WM_PC8          4'h1
`define TWM_WM_PC9          4'h2
`define TWM_WM_PC10         4'h3
`define TWM_WM_CTC_MATCH    4'h4
`define TWM_WM_FAST8        4'h5
`define TWM_WM_FAST9        4'h6
`define TWM_WM_FAST10       4'h7
`define TWM_WM_PFC_CAPT     4'h8
`define TWM_WM_PFC_MATCH    4'h9
`define TWM_WM_PC_CAPT      4'hA
`define TWM_WM_PC_MATCH     4'hB
`define TWM_WM_CTC_CAPT     4'hC
`define TWM_WM_RSVD         4'hD
`define TWM_WM_FAST_CAPT    4'hE
`define TWM_WM_FAST_MATCH   4'hF

// Fixed top values
`define TWM_TOP_MAX         16'hFFFF
`define TWM_TOP_8BIT        16'h00FF
`define TWM_TOP_9BIT        16'h01FF
`define TWM_TOP_10BIT       16'h03FF
`define TWM_BOTTOM          16'h0000

`endif

// File: verilog/twm_chan.v
/*
  One compare output channel: turns the two-bit output mode and the
  waveform class into set, clear and toggle actions on the output level.
  Assumes match, at_top and count_down come from the counter core on
  the same clock and are only acted on while tick is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"

module twm_chan
#(
  parameter CHAN_IS_A = 0
)
(
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       tick,
  input  wire       mode_fast,
  input  wire       mode_dual,
  input  wire       wsel_top_bit,
  input  wire [1:0] out_mode,
  input  wire       match,
  input  wire       at_top,
  input  wire       match_is_top,
  input  wire       count_down,
  output reg        connected,
  output reg        level
);

  reg next_level;

  // Pin ownership; reserved PWM toggle codes stay off the pin
  always @*
  begin
    if (out_mode == `TWM_OM_OFF)
      connected = 1'b0;
    else if ((mode_fast || mode_dual) && out_mode == `TWM_OM_TOGGLE)
      connected = wsel_top_bit && (CHAN_IS_A != 0);
    else
      connected = 1'b1;
  end

  // Next output level per waveform class
  always @*
  begin
    next_level = level;
    if (tick && connected)
    begin
      if (out_mode == `TWM_OM_TOGGLE)
      begin
        if (match)
          next_level = ~level;
      end
      else if (mode_fast)
      begin
        // Top wins; a match at top would glitch the pulse edge
        if (at_top)
          next_level = (out_mode == `TWM_OM_CLEAR);
        else if (match && !match_is_top)
          next_level = (out_mode == `TWM_OM_SET);
      end
      else if (mode_dual)
      begin
        if (match)
          next_level = (out_mode == `TWM_OM_CLEAR) ? count_down
                                                   : ~count_down;
      end
      else if (match)
        next_level = (out_mode == `TWM_OM_SET);
    end
  end

  // Output level register
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      level <= 1'b0;
    else
      level <= next_level;
  end

endmodule
`default_nettype wire

// File: verilog/twm_top.v
/*
  Waveform mode control slice of a 16-bit timer: control and compare
  registers on a plain register port, waveform mode decode, compare
  double buffering, overflow flag, and three compare output channels.
  Assumes the counter core runs on ref_clk and gives its value, its
  direction and a one-cycle tick per timer step; port data and pin
  direction bits come from port logic on the same clock.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
// Contract
// - A nonzero channel output mode hands that channel's pin to the compare output.
// - Pin driver is enabled only when the pin direction bit says output.
// - Non-PWM: 00 off, 01 toggle, 10 low, 11 high on match.
// - Fast PWM: 10 clears on match, sets at top; 11 the inverse.
// - PWM mode 01: off unless mode top bit set; then toggles A only.
// - Fast PWM with compare equal top: ignore match, act only at top.
// - Dual-slope: 10 clears on up match, sets on down match; 11 inverse.
// - Mode is control A bits 1:0 with two high bits from control B.
// - Mode 0: top 0xFFFF, immediate compare update, overflow at MAX.
// - Modes 1-3: phase correct, tops 0x00FF/0x01FF/0x03FF, update top, flag bottom.
// - Modes 5-7,14,15: fast PWM, update and overflow flag at top.
// - Modes 4,12: clear on match, top from A or capture, immediate, MAX.
// - Modes 8,9 update at bottom; 10,11 at top; all flag at bottom.
// - Capture as top disconnects the capture input pin.
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"

module twm_top
#(
  parameter NCHAN = 3
)
(
  input  wire         ref_clk,
  input  wire         resetn,
  input  wire [3:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  input  wire [15:0]  cnt_value,
  input  wire         cnt_down,
  input  wire         cnt_tick,
  input  wire [2:0]   port_data,
  input  wire [2:0]   pin_dir,
  output wire [2:0]   pin_out,
  output wire [2:0]   pin_oe_n,
  output reg  [15:0]  top_value,
  output reg          dual_slope,
  output reg          clear_on_match_mode,
  output wire [2:0]   clock_select,
  output wire         overflow_set,
  output reg          overflow_flag,
  output wire         capture_pin_disconnect,
  output wire [15:0]  match_value_a,
  output wire [15:0]  match_value_b,
  output wire [15:0]  match_value_c
);

  // Stored registers
  reg  [7:0]          control_a;
  reg  [7:0]          control_b;
  reg  [15:0]         capture_value;
  reg  [16*NCHAN-1:0] match_buf;
  reg  [16*NCHAN-1:0] match_act;

  // Decoded mode
  wire [3:0]          waveform_select;
  wire [1:0]          waveform_select_low;
  wire [1:0]          waveform_select_high;
  reg                 mode_fast;
  reg                 top_from_capt;
  reg                 top_from_match;
  reg                 upd_immediate;
  reg                 upd_at_top;
  reg                 upd_at_bottom;
  reg                 ovf_at_max;
  reg                 ovf_at_top;
  reg                 ovf_at_bottom;

  // Counter events
  wire                at_top;
  wire                at_bottom;
  wire                at_max;
  wire                load_act;
  wire                ovf_clear;

  // Per channel
  wire [NCHAN-1:0]    chan_conn;
  wire [NCHAN-1:0]    chan_level;
  wire [2*NCHAN-1:0]  chan_mode;

  reg  [7:0]          next_rdata;

  assign waveform_select_low  = control_a[`TWM_CA_WSEL_HI:`TWM_CA_WSEL_LO];
  assign waveform_select_high = control_b[`TWM_CB_WSEL_HI:`TWM_CB_WSEL_LO];
  // Four-bit mode spans both control registers
  assign waveform_select = {waveform_select_high,
                            waveform_select_low};
  assign clock_select    = control_b[`TWM_CB_CSEL_HI:`TWM_CB_CSEL_LO];

  assign chan_mode = {control_a[`TWM_CA_MODE_C_HI:`TWM_CA_MODE_C_LO],
                      control_a[`TWM_CA_MODE_B_HI:`TWM_CA_MODE_B_LO],
                      control_a[`TWM_CA_MODE_A_HI:`TWM_CA_MODE_A_LO]};

  assign match_value_a = match_act[15:0];
  assign match_value_b = match_act[31:16];
  assign match_value_c = match_act[47:32];

  // Mode decode: counting sequence, top source, update and flag points
  always @*
  begin
    mode_fast           = 1'b0;
    dual_slope          = 1'b0;
    clear_on_match_mode = 1'b0;
    top_from_capt       = 1'b0;
    top_from_match      = 1'b0;
    upd_immediate       = 1'b0;
    upd_at_top          = 1'b0;
    upd_at_bottom       = 1'b0;
    ovf_at_max          = 1'b0;
    ovf_at_top          = 1'b0;
    ovf_at_bottom       = 1'b0;
    top_value           = `TWM_TOP_MAX;
    case (waveform_select)
      `TWM_WM_NORMAL:
      begin
        upd_immediate = 1'b1;
        ovf_at_max    = 1'b1;
      end
      `TWM_WM_PC8, `TWM_WM_PC9, `TWM_WM_PC10:
      begin
        dual_slope    = 1'b1;
        upd_at_top    = 1'b1;
        ovf_at_bottom = 1'b1;
        top_value     = (waveform_select == `TWM_WM_PC8) ? `TWM_TOP_8BIT :
                        (waveform_select == `TWM_WM_PC9) ? `TWM_TOP_9BIT :
                        `TWM_TOP_10BIT;
      end
      `TWM_WM_CTC_MATCH, `TWM_WM_CTC_CAPT:
      begin
        clear_on_match_mode = 1'b1;
        upd_immediate       = 1'b1;
        ovf_at_max          = 1'b1;
        top_from_capt       = (waveform_select == `TWM_WM_CTC_CAPT);
        top_from_match      = (waveform_select == `TWM_WM_CTC_MATCH);
      end
      `TWM_WM_FAST8, `TWM_WM_FAST9, `TWM_WM_FAST10:
      begin
        mode_fast  = 1'b1;
        upd_at_top = 1'b1;
        ovf_at_top = 1'b1;
        top_value  = (waveform_select == `TWM_WM_FAST8) ? `TWM_TOP_8BIT :
                     (waveform_select == `TWM_WM_FAST9) ? `TWM_TOP_9BIT :
                     `TWM_TOP_10BIT;
      end
      `TWM_WM_PFC_CAPT, `TWM_WM_PFC_MATCH:
      begin
        dual_slope     = 1'b1;
        upd_at_bottom  = 1'b1;
        ovf_at_bottom  = 1'b1;
        top_from_capt  = (waveform_select == `TWM_WM_PFC_CAPT);
        top_from_match = (waveform_select == `TWM_WM_PFC_MATCH);
      end
      `TWM_WM_PC_CAPT, `TWM_WM_PC_MATCH:
      begin
        dual_slope     = 1'b1;
        upd_at_top     = 1'b1;
        ovf_at_bottom  = 1'b1;
        top_from_capt  = (waveform_select == `TWM_WM_PC_CAPT);
        top_from_match = (waveform_select == `TWM_WM_PC_MATCH);
      end
      `TWM_WM_FAST_CAPT, `TWM_WM_FAST_MATCH:
      begin
        mode_fast      = 1'b1;
        upd_at_top     = 1'b1;
        ovf_at_top     = 1'b1;
        top_from_capt  = (waveform_select == `TWM_WM_FAST_CAPT);
        top_from_match = (waveform_select == `TWM_WM_FAST_MATCH);
      end
      default:
      begin
        // Reserved code: plain counting, no waveform class
        upd_immediate = 1'b1;
        ovf_at_max    = 1'b1;
      end
    endcase
    if (top_from_capt)
      top_value = capture_value;
    else if (top_from_match)
      top_value = match_act[15:0];
  end

  // Capture pin is dropped whenever it holds the top
  assign capture_pin_disconnect = top_from_capt;

  assign at_top    = (cnt_value == top_value);
  assign at_bottom = (cnt_value == `TWM_BOTTOM);
  assign at_max    = (cnt_value == `TWM_TOP_MAX);

  // Buffered compare values move to the active copy at the mode's point
  assign load_act = upd_immediate ||
                    (cnt_tick && ((upd_at_top && at_top) ||
                                  (upd_at_bottom && at_bottom)));

  assign overflow_set = cnt_tick &&
                        ((ovf_at_max && at_max) ||
                         (ovf_at_top && at_top) ||
                         (ovf_at_bottom && at_bottom));

  assign ovf_clear = reg_wr && (reg_addr == `TWM_OFS_STATUS) &&
                     reg_wdata[`TWM_ST_OVF];

  // Control, capture and overflow registers
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      control_a     <= `TWM_RST_CTRL_A;
      control_b     <= `TWM_RST_CTRL_B;
      capture_value <= `TWM_RST_WORD;
      overflow_flag <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `TWM_OFS_CTRL_A)
        control_a <= reg_wdata;
      if (reg_wr && reg_addr == `TWM_OFS_CTRL_B)
        control_b <= reg_wdata & `TWM_CB_READ_MASK;
      if (reg_wr && reg_addr == `TWM_OFS_CAPT_LO)
        capture_value[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == `TWM_OFS_CAPT_HI)
        capture_value[15:8] <= reg_wdata;
      // Set beats a clear in the same cycle so no overflow is lost
      if (overflow_set)
        overflow_flag <= 1'b1;
      else if (ovf_clear)
        overflow_flag <= 1'b0;
    end
  end

  // Per-channel compare registers and waveform units
  genvar gi;
  generate
    for (gi = 0; gi < NCHAN; gi = gi + 1)
    begin : g_chan
      localparam integer OFS_LO = `TWM_OFS_MATCH_A_LO + gi * 2;
      localparam integer OFS_HI = `TWM_OFS_MATCH_A_HI + gi * 2;
      wire       match;
      wire       match_is_top;

      // Byte writes land in the buffer, never straight in the active copy
      always @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          match_buf[gi*16 +: 16] <= `TWM_RST_WORD;
          match_act[gi*16 +: 16] <= `TWM_RST_WORD;
        end
        else
        begin
          if (reg_wr && reg_addr == OFS_LO[3:0])
            match_buf[gi*16 +: 8] <= reg_wdata;
          if (reg_wr && reg_addr == OFS_HI[3:0])
            match_buf[gi*16+8 +: 8] <= reg_wdata;
          if (load_act)
            match_act[gi*16 +: 16] <= match_buf[gi*16 +: 16];
        end
      end

      assign match        = (cnt_value == match_act[gi*16 +: 16]);
      assign match_is_top = (match_act[gi*16 +: 16] == top_value);

      twm_chan
      #(
        .CHAN_IS_A (gi == 0)
      )
      u_chan
      (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .tick         (cnt_tick),
        .mode_fast    (mode_fast),
        .mode_dual    (dual_slope),
        .wsel_top_bit (waveform_select[3]),
        .out_mode     (chan_mode[gi*2 +: 2]),
        .match        (match),
        .at_top       (at_top),
        .match_is_top (match_is_top),
        .count_down   (cnt_down),
        .connected    (chan_conn[gi]),
        .level        (chan_level[gi])
      );

      // Override the port only while connected; driver needs output dir
      assign pin_out[gi]  = chan_conn[gi] ? chan_level[gi]
                                          : port_data[gi];
      assign pin_oe_n[gi] = ~pin_dir[gi];
    end
  endgenerate

  // Read mux; unmapped offsets read as zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `TWM_OFS_CTRL_A:     next_rdata = control_a;
      `TWM_OFS_CTRL_B:     next_rdata = control_b & `TWM_CB_READ_MASK;
      `TWM_OFS_MATCH_A_LO: next_rdata = match_buf[7:0];
      `TWM_OFS_MATCH_A_HI: next_rdata = match_buf[15:8];
      `TWM_OFS_MATCH_B_LO: next_rdata = match_buf[23:16];
      `TWM_OFS_MATCH_B_HI: next_rdata = match_buf[31:24];
      `TWM_OFS_MATCH_C_LO: next_rdata = match_buf[39:32];
      `TWM_OFS_MATCH_C_HI: next_rdata = match_buf[47:40];
      `TWM_OFS_CAPT_LO:    next_rdata = capture_value[7:0];
      `TWM_OFS_CAPT_HI:    next_rdata = capture_value[15:8];
      `TWM_OFS_STATUS:
      begin
        next_rdata[`TWM_ST_OVF]      = overflow_flag;
        next_rdata[`TWM_ST_DUAL]     = dual_slope;
        next_rdata[`TWM_ST_FAST]     = mode_fast;
        next_rdata[`TWM_ST_CAPT_OFF] = top_from_capt;
        next_rdata[`TWM_ST_LEVEL_HI:`TWM_ST_LEVEL_LO] = chan_level;
      end
      default:             next_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// File: verif/twm_checker.sv
/*
  Checker for the waveform mode control slice: mode decode, pins, flag.
  Assumes it is bound to twm_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"
module twm_checker
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic [15:0] cnt_value,
  input wire logic        cnt_tick,
  input wire logic [2:0]  port_data,
  input wire logic [2:0]  pin_dir,
  input wire logic [2:0]  pin_out,
  input wire logic [2:0]  pin_oe_n,
  input wire logic [15:0] top_value,
  input wire logic        dual_slope,
  input wire logic        clear_on_match_mode,
  input wire logic        overflow_set,
  input wire logic        overflow_flag,
  input wire logic        capture_pin_disconnect,
  input wire logic [2:0]  clock_select,
  input wire logic [15:0] match_value_a,
  input wire logic [15:0] match_value_b,
  input wire logic [15:0] match_value_c
);
  logic [7:0] sh_a;
  logic [1:0] sh_b;
  logic [2:0] sh_cs;
  logic [3:0] mode;
  logic [2:0] off;
  logic       fast;
  logic       dual;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Shadow of the control bytes, so the mode is known without peeking
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sh_a <= 8'h00;
      {sh_b, sh_cs} <= 5'h00;
    end
    else if (reg_wr && reg_addr == `TWM_OFS_CTRL_A)
      sh_a <= reg_wdata;
    else if (reg_wr && reg_addr == `TWM_OFS_CTRL_B)
      {sh_b, sh_cs} <= reg_wdata[4:0];
  end
  // Mode and class decode from the shadow copy
  assign mode = {sh_b, sh_a[1:0]};
  assign off = {sh_a[3:2] == 2'h0, sh_a[5:4] == 2'h0, sh_a[7:6] == 2'h0};
  assign fast = mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  assign dual = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  chk_oe_dir: assert property (pin_oe_n == ~pin_dir)
    else $error("pin driver enable does not follow direction");
  chk_off_port: assert property (
    ((pin_out ^ port_data) & off) == 3'h0)
    else $error("disconnected channel does not pass port data");
  chk_top_normal: assert property (mode == 4'h0 |->
    top_value == `TWM_TOP_MAX) else $error("normal mode top wrong");
  chk_top_fixed: assert property (
    !mode[3] && mode[1:0] != 2'h0 |->
    top_value == (mode[1:0] == 2'h1 ? `TWM_TOP_8BIT : mode[1:0] == 2'h2 ?
    `TWM_TOP_9BIT : `TWM_TOP_10BIT)) else $error("fixed top wrong");
  chk_dual_class: assert property (dual_slope == dual)
    else $error("dual slope class wrong");
  chk_ctc_class: assert property (clear_on_match_mode ==
    (mode == 4'h4 || mode == 4'hC)) else $error("clear on match class wrong");
  chk_capt_off: assert property (capture_pin_disconnect ==
    (mode inside {4'h8, 4'hA, 4'hC, 4'hE})) else $error("capture pin wrong");
  chk_ovf_max: assert property (cnt_tick &&
    cnt_value == `TWM_TOP_MAX && mode inside {4'h0, 4'h4, 4'hC} |->
    overflow_set) else $error("no overflow at max");
  chk_ovf_top: assert property (cnt_tick && fast &&
    cnt_value == top_value |-> overflow_set) else $error("no overflow at top");
  chk_ovf_bottom: assert property (cnt_tick && dual &&
    cnt_value == `TWM_BOTTOM |-> overflow_set)
    else $error("no overflow at bottom");
  chk_ovf_sticky: assert property (overflow_set |=> overflow_flag)
    else $error("overflow flag not raised");
  chk_clock_sel: assert property (clock_select == sh_cs)
    else $error("clock select does not follow control b");
  chk_top_match: assert property (
    mode inside {4'h4, 4'h9, 4'hB, 4'hF} |-> top_value == match_value_a)
    else $error("top not taken from match a");
  // Fast PWM may only move the active compare copy on a tick at top
  chk_match_hold: assert property (
    fast && !(cnt_tick && cnt_value == top_value) |=>
    $stable({match_value_a, match_value_b, match_value_c}))
    else $error("compare value moved off top in fast pwm");
endmodule
bind twm_top twm_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .cnt_value(cnt_value), .cnt_tick(cnt_tick), .port_data(port_data),
  .pin_dir(pin_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .top_value(top_value), .dual_slope(dual_slope),
  .clear_on_match_mode(clear_on_match_mode), .overflow_set(overflow_set),
  .overflow_flag(overflow_flag), .clock_select(clock_select),
  .match_value_a(match_value_a), .match_value_b(match_value_b),
  .match_value_c(match_value_c),
  .capture_pin_disconnect(capture_pin_disconnect));
`default_nettype wire

// File: verif/twm_pin_load.sv
/*
  Board side of the three compare pins: resolves the wire level.
  Assumes each pin has a pull-up that wins while the driver is off.
*/
`timescale 1ns/1ps
`default_nettype none
module twm_pin_load
(
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  output wire logic [2:0] pin_level
);
  // Released pins read the pull-up, never a stale driven value
  assign pin_level = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule
`default_nettype wire

// File: verif/twm_tb_top.sv
/*
  Self-checking bench for the waveform mode control slice.
  Assumes the checker is bound to the design and drives the counter side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.vh"
module twm_tb_top;
  logic        ref_clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire  [7:0]  reg_rdata;
  logic [15:0] cnt_value;
  logic        cnt_down;
  logic        cnt_tick;
  logic [2:0]  port_data;
  logic [2:0]  pin_dir;
  wire  [2:0]  pin_out;
  wire  [2:0]  pin_oe_n;
  wire  [2:0]  pin_level;
  logic [8:0]  exp_q[$];
  logic [8:0]  note;
  logic        rd_seen;
  logic        look;
  logic        look_seen;
  logic [1:0]  c;
  logic [15:0] mv;
  integer      fail_count;
  integer      comparisons;
  integer      seed;
  integer      i;
  twm_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cnt_value(cnt_value), .cnt_down(cnt_down),
    .cnt_tick(cnt_tick), .port_data(port_data), .pin_dir(pin_dir),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .top_value(), .dual_slope(),
    .clear_on_match_mode(), .clock_select(), .overflow_set(),
    .overflow_flag(), .capture_pin_disconnect(), .match_value_a(),
    .match_value_b(), .match_value_c());
  twm_pin_load u_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_level(pin_level));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Expected byte is noted first, compared by the monitor a cycle later
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic look_pins(input logic [2:0] e);
    exp_q.push_back({4'h8, 2'h0, e});
    @(posedge ref_clk);
    look <= 1'b1;
    @(posedge ref_clk);
    look <= 1'b0;
  endtask
  task automatic tick(input logic [15:0] v, input logic d);
    @(posedge ref_clk);
    cnt_value <= v;
    cnt_down <= d;
    cnt_tick <= 1'b1;
    @(posedge ref_clk);
    cnt_tick <= 1'b0;
  endtask
  task automatic set_match(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Monitor: a result appears, the oldest note is taken and compared
  always @(posedge ref_clk)
  begin
    rd_seen <= reg_rd;
    look_seen <= look;
    if (rd_seen || look_seen)
    begin
      if (exp_q.size() == 0)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] queue expected note seen none");
      end
      else
      begin
        note = exp_q.pop_front();
        if (note[8])
          check({5'h00, pin_level}, note[7:0], "pin_level");
        else
          check(reg_rdata, note[7:0], "reg_rdata");
      end
    end
  end
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    $display("[ERR] run expected finish seen timeout");
    end_sim;
  end
  initial
  begin
    seed = 64;
    fail_count = 0;
    comparisons = 0;
    resetn = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 14'h0000;
    {cnt_value, cnt_down, cnt_tick} = 18'h00000;
    {port_data, pin_dir, look} = 7'h00;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`TWM_OFS_CTRL_A, `TWM_RST_CTRL_A);
    wr(4'hB, 8'h5A);
    rd(4'hB, 8'h00);
    wr(`TWM_OFS_CTRL_B, 8'hFF);
    rd(`TWM_OFS_CTRL_B, 8'hDF);
    $display("test reset done");
    for (i = 0; i < 16; i = i + 1)
    begin
      wr(`TWM_OFS_CTRL_A, {6'h00, i[1:0]});
      wr(`TWM_OFS_CTRL_B, {3'h0, i[3:2], i[2:0]});
      rd(`TWM_OFS_STATUS, {4'h0, i inside {8, 10, 12, 14},
        i inside {5, 6, 7, 14, 15}, i inside {1, 2, 3, 8, 9, 10, 11},
        1'b0});
    end
    wr(`TWM_OFS_CTRL_A, 8'h00);
    wr(`TWM_OFS_CTRL_B, 8'h00);
    tick(`TWM_TOP_MAX, 1'b0);
    rd(`TWM_OFS_STATUS, 8'h01);
    wr(`TWM_OFS_STATUS, 8'h01);
    rd(`TWM_OFS_STATUS, 8'h00);
    $display("test modes done");
    mv = 16'($random(seed));
    pin_dir <= 3'b010;
    look_pins(3'b101);
    pin_dir <= 3'b111;
    port_data <= 3'b101;
    look_pins(3'b101);
    for (i = 2; i < 8; i = i + 1)
      wr(i[3:0], i[0] ? mv[15:8] : mv[7:0]);
    for (i = 0; i < 4; i = i + 1)
    begin
      c = (i < 2) ? 2'h3 - i[1:0] : 2'h1;
      wr(`TWM_OFS_CTRL_A, {c, c, c, 2'h0});
      tick(mv, 1'b0);
      look_pins(i[0] ? 3'b000 : 3'b111);
    end
    $display("test non-pwm done");
    wr(`TWM_OFS_CTRL_B, 8'h08);
    wr(`TWM_OFS_CTRL_A, 8'hA9);
    set_match(`TWM_OFS_MATCH_A_LO, 16'h0040);
    set_match(`TWM_OFS_MATCH_B_LO, 16'h0080);
    set_match(`TWM_OFS_MATCH_C_LO, `TWM_TOP_8BIT);
    tick(`TWM_TOP_8BIT, 1'b0);
    tick(16'h0040, 1'b0);
    tick(16'h0080, 1'b0);
    look_pins(3'b100);
    wr(`TWM_OFS_CTRL_A, 8'hFD);
    tick(`TWM_TOP_8BIT, 1'b0);
    tick(16'h0040, 1'b0);
    look_pins(3'b001);
    wr(`TWM_OFS_CTRL_A, 8'h55);
    port_data <= 3'b011;
    look_pins(3'b011);
    set_match(`TWM_OFS_CAPT_LO, 16'h0100);
    wr(`TWM_OFS_CTRL_B, 8'h18);
    wr(`TWM_OFS_CTRL_A, 8'h56);
    tick(16'h0100, 1'b0);
    tick(16'h0040, 1'b0);
    look_pins(3'b010);
    $display("test fast pwm done");
    wr(`TWM_OFS_CTRL_B, 8'h00);
    wr(`TWM_OFS_CTRL_A, 8'h81);
    set_match(`TWM_OFS_MATCH_A_LO, 16'h0080);
    tick(`TWM_TOP_8BIT, 1'b0);
    tick(`TWM_BOTTOM, 1'b1);
    for (i = 0; i < 4; i = i + 1)
    begin
      if (i == 2)
        wr(`TWM_OFS_CTRL_A, 8'hC1);
      tick(16'h0080, i[0] ^ i[1] ^ 1'b1);
      // Clear mode: high after a down match; set mode: high after an up match
      look_pins({2'b01, ~i[0]});
    end
    $display("test dual slope done");
    i = 0;
    while (exp_q.size() != 0 && i < 10)
    begin
      @(posedge ref_clk);
      i = i + 1;
    end
    if (exp_q.size() != 0)
    begin
      fail_count = fail_count + 1;
      $display("[ERR] queue expected empty seen %0d", exp_q.size());
    end
    end_sim;
  end
endmodule
`default_nettype wire
